// ### rtl/soc_pkg.sv
// soc_pkg: constants and types of the system option registers.
// assumes a byte-wide register view placed in the low lane of a 32-bit bus.
package soc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_EEMAP = 8'h37;
    localparam logic [7:0] IDX_SYSTEM_OPTIONS_TWO  = 8'h38;
    localparam logic [7:0] IDX_OPT1  = 8'h39;
    // field positions, options one
    localparam int B_ANALOG_POWER_BIT = 7;
    localparam int B_PUMP_CLOCK_SELECT = 6;
    localparam int B_MASKABLE_INT_EDGE_BIT = 5;
    localparam int B_DLY  = 4;
    localparam int B_CME  = 3;
    localparam int B_FORCE_MONITOR_BIT = 2;
    // field positions, options two
    localparam int B_INSTR_START_DRIVE_BIT = 7;
    localparam int B_PORT_C_OPEN_DRAIN_BIT  = 6;
    localparam int B_STRETCH_BIT = 5;
    localparam int B_VIS   = 4;
    localparam int B_BIT_ORDER_BIT  = 3;
    localparam int B_EXTRA_RATE_BIT  = 2;
    localparam int B_CLOCK_OUTPUT_SOURCE_BIT = 1;
    localparam int B_NONMASKABLE_INT_EDGE_BIT = 0;
    // reset values and write masks
    localparam logic [3:0] EE_RST    = 4'h0;
    localparam logic [7:0] OPT1_RST  = 8'h10;
    localparam logic [7:0] SYSTEM_OPTIONS_TWO_RST  = 8'h00;
    localparam logic [7:0] OPT1_PROT = 8'h37;
    localparam logic [7:0] SYSTEM_OPTIONS_TWO_FREE = 8'hEC;
    // timing
    localparam int         CLK_MHZ    = 100;
    localparam int         ADC_SET_US = 100;
    localparam int         ADC_CYC    = ADC_SET_US * CLK_MHZ;
    localparam logic [6:0] WIN_CYC    = 7'h40;
    localparam logic [11:0] DLY_SHORT = 12'h080;
    localparam logic [11:0] DLY_LONG  = 12'hFE0;
    localparam logic [11:0] DLY_FAST  = 12'h004;
    typedef enum logic [1:0] {
        MODE_BOOT   = 2'b00,
        MODE_TEST   = 2'b01,
        MODE_SINGLE = 2'b10,
        MODE_EXP    = 2'b11
    } soc_mode_e;
    typedef enum logic {
        DL_RUN  = 1'b0,
        DL_HOLD = 1'b1
    } soc_dl_e;
    typedef struct packed {
        logic [3:0] eeprom_position_field;
        logic       analog_power_bit;
        logic       pump_clock_select;
        logic [1:0] watchdog_rate_bits;
        logic       port_c_open_drain_bit;
        logic       bit_order_bit;
        logic       extra_rate_bit;
        logic       clock_output_source_bit;
    } soc_cfg_s;
endpackage : soc_pkg

// ### rtl/soc_regs.sv
// soc_regs: system option registers on a classic Wishbone slave.
// assumes mode_i comes from same-clock mode latch logic and is taken
// while rst_i is high; pins irq, nmi and rc tick are asynchronous.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R01] eeprom map always readable; position bits written once per reset in normal modes
// [R02] eeprom occupies xE00 to xFFF, x being the position field
// [R03] low nibble of eeprom map register reads zero
// [R04] protected option-one fields: one write within 64 cycles, normal modes only
// [R05] analog power bit powers the converter; software waits 100 us
// [R06] pump clock select picks rc clock when set, bus clock when clear
// [R07] maskable interrupt: falling edge when edge bit set, low level otherwise
// [R08] start delay bit set by reset; clear means resume within four cycles
// [R09] stabilisation delay is 128 or 4064 cycles by manufacturing option
// [R10] monitor runs when enabled; forced monitor stays on; slow clock resets
// [R11] two watchdog rate bits scale the watchdog timeout
// [R12] expanded modes: instruction start pin low, optional high drive pulse
// [R13] port c open drain bit makes port c outputs open drain
// [R14] stretch lengthens off-chip accesses in range set by rom placement
// [R15] stretch bit cleared by reset, no effect in single chip or boot
// [R16] visibility bit resets by mode; once in normal, free in special
// [R17] expanded: visibility bit shows internal reads, never when secure
// [R18] single chip: visibility bit holds bus clock pin low when set
// [R19] bit order bit selects lsb first serial shifting
// [R20] extra rate bit adds divide by four to serial clock chain
// [R21] clock output source written once; raw crystal or quadrupled clock
// [R22] nonmaskable edge bit written once; falling edge or low level
// [R23] special mode indicator set in boot and test modes
// [R24] clock output pin driven only when clock output enable set
// [R25] written flags per write-once field, cleared by reset
module soc_regs
    import soc_pkg::*;
#(
    parameter bit LONG_DELAY     = 1'b1,   // manufacturing delay option
    parameter int ADC_SETTLE_CYC = ADC_CYC // converter settle count
) (
    input  wire logic        clk_i,            // 100 MHz bus clock
    input  wire logic        rst_i,            // sync reset, high
    input  wire logic [7:0]  adr_i,            // wishbone byte address
    input  wire logic [31:0] dat_i,            // wishbone write data
    output logic      [31:0] dat_o,            // wishbone read data
    input  wire logic        we_i,             // wishbone write
    input  wire logic [3:0]  sel_i,            // wishbone byte enables
    input  wire logic        cyc_i,            // wishbone cycle
    input  wire logic        stb_i,            // wishbone strobe
    output logic             ack_o,            // wishbone ack
    input  wire logic [1:0]  mode_i,           // {modb, moda}
    input  wire logic        secure_i,         // secure expanded mode
    input  wire logic        clk_out_en_i,     // clock output enable bit
    input  wire logic        rom_placement_i,  // rom placement bit
    input  wire logic [15:0] cpu_addr_i,       // cpu address
    input  wire logic        ext_access_i,     // off-chip access now
    input  wire logic        irq_n_i,          // maskable irq pin
    input  wire logic        nonmaskable_int_pin_n_i,         // nonmaskable irq pin
    input  wire logic        irq_ack_i,        // clears irq edge latch
    input  wire logic        nonmaskable_int_pin_ack_i,       // clears nmi edge latch
    input  wire logic        rc_tick_i,        // rc oscillator pin
    input  wire logic        stop_exit_i,      // leave stop mode pulse
    input  wire logic        instr_start_i,    // instruction begins
    input  wire logic        clk_slow_i,       // monitor detector flag
    output soc_cfg_s         cfg_o,            // register fields
    output logic             special_mode_o,   // boot or test mode
    output logic             eeprom_sel_o,     // address hits eeprom
    output logic             pump_clk_en_o,    // pump clock enable
    output logic             adc_ready_o,      // converter settled
    output logic             irq_req_o,        // maskable request
    output logic             nonmaskable_int_pin_req_o,       // nonmaskable request
    output logic             cpu_run_o,        // delay complete
    output logic             monitor_en_o,     // clock monitor on
    output logic             clk_fail_rst_o,   // clock failure reset
    output logic             lir_o,            // instr start pin out
    output logic             lir_oe_n_o,       // instr start pin oe
    output logic             stretch_o,        // stretch this access
    output logic             read_vis_o,       // internal read vis
    output logic             busclk_low_o,     // hold bus clock low
    output logic             clock_output_pin_oe_n_o       // clock output pin oe
);

    typedef struct packed {
        logic        ack;
        logic [7:0]  rdata;
        soc_mode_e   mode;
        logic [3:0]  ee;
        logic [7:0]  opt1;
        logic [7:0]  system_options_two;
        logic        ee_wr;
        logic        opt1_wr;
        logic        vis_wr;
        logic        x4_wr;
        logic        xe_wr;
        logic [6:0]  win;
        logic [13:0] adc_cnt;
        logic [2:0]  irq_s;
        logic [2:0]  nonmaskable_int_pin_s;
        logic [2:0]  rc_s;
        logic        irq_pend;
        logic        nonmaskable_int_pin_pend;
        soc_dl_e     dl;
        logic [11:0] dl_cnt;
        logic        lir_lo;
        logic        lir_hi;
    } soc_state_s;

    soc_state_s q;
    soc_state_s d;

    // register decode, used for each of the three registers
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] idx);
        reg_hit = (a[7:2] == idx[5:0]);
    endfunction : reg_hit

    localparam logic [11:0] DLY_POR = LONG_DELAY ? DLY_LONG : DLY_SHORT;
    localparam logic [13:0] ADC_MAX = ADC_SETTLE_CYC[13:0];

    logic req;
    logic wr;
    logic special;
    logic expanded;
    logic in_window;
    logic irq_fall;
    logic nonmaskable_int_pin_fall;
    logic [7:0] wb;

    // mode decode and bus request qualification
    assign req       = cyc_i & stb_i & ~q.ack;
    assign wr        = req & we_i & sel_i[0];
    assign wb        = dat_i[7:0];
    assign special   = ~q.mode[1];              // [R23]
    assign expanded  = q.mode[0];
    assign in_window = q.win < WIN_CYC;
    assign irq_fall  = q.irq_s[2] & ~q.irq_s[1];
    assign nonmaskable_int_pin_fall = q.nonmaskable_int_pin_s[2] & ~q.nonmaskable_int_pin_s[1];

    // next-state logic
    always_comb begin
        d = q;
        d.ack = req;
        d.win = in_window ? q.win + 7'h01 : q.win;
        // only the second and third stages of each synchroniser are looked at
        d.irq_s  = {q.irq_s[1], q.irq_s[0], irq_n_i};
        d.nonmaskable_int_pin_s = {q.nonmaskable_int_pin_s[1], q.nonmaskable_int_pin_s[0], nonmaskable_int_pin_n_i};
        d.rc_s   = {q.rc_s[1], q.rc_s[0], rc_tick_i};
        // read path; unmapped addresses answer zero
        d.rdata = 8'h00;
        if (req && !we_i) begin
            if (reg_hit(adr_i, IDX_EEMAP))
                d.rdata = {q.ee, 4'h0};          // [R01] [R03]
            else if (reg_hit(adr_i, IDX_OPT1))
                d.rdata = q.opt1;
            else if (reg_hit(adr_i, IDX_SYSTEM_OPTIONS_TWO))
                d.rdata = q.system_options_two;
        end
        // eeprom position, once per reset in normal modes
        if (wr && reg_hit(adr_i, IDX_EEMAP) && (special || !q.ee_wr)) begin
            d.ee    = wb[7:4];                   // [R01] [R25]
            d.ee_wr = 1'b1;
        end
        // option one: free bits always, guarded bits early or special
        if (wr && reg_hit(adr_i, IDX_OPT1)) begin
            d.opt1 = (q.opt1 & OPT1_PROT) | (wb & ~OPT1_PROT);
            if (special || (!q.opt1_wr && in_window)) begin
                d.opt1    = wb;                  // [R04] [R25]
                d.opt1_wr = 1'b1;
            end
            // forced monitor can only be set until the next reset
            d.opt1[B_FORCE_MONITOR_BIT] = q.opt1[B_FORCE_MONITOR_BIT] | d.opt1[B_FORCE_MONITOR_BIT]; // [R10]
        end
        // option two: per-field write-once guards
        if (wr && reg_hit(adr_i, IDX_SYSTEM_OPTIONS_TWO)) begin
            d.system_options_two = (q.system_options_two & ~SYSTEM_OPTIONS_TWO_FREE) | (wb & SYSTEM_OPTIONS_TWO_FREE); // [R13]
            if (special || !q.vis_wr) begin
                d.system_options_two[B_VIS] = wb[B_VIS];       // [R16]
                d.vis_wr      = 1'b1;
            end
            if (special || !q.x4_wr) begin
                d.system_options_two[B_CLOCK_OUTPUT_SOURCE_BIT] = wb[B_CLOCK_OUTPUT_SOURCE_BIT];   // [R21]
                d.x4_wr         = 1'b1;
            end
            if (special || !q.xe_wr) begin
                d.system_options_two[B_NONMASKABLE_INT_EDGE_BIT] = wb[B_NONMASKABLE_INT_EDGE_BIT];   // [R22]
                d.xe_wr         = 1'b1;
            end
        end
        // converter settle counter restarts at each power-up
        if (!q.opt1[B_ANALOG_POWER_BIT])
            d.adc_cnt = 14'h0000;                // [R05]
        else if (q.adc_cnt != ADC_MAX)
            d.adc_cnt = q.adc_cnt + 14'h0001;
        // edge latches; a new edge beats a same-cycle acknowledge
        if (irq_ack_i)
            d.irq_pend = 1'b0;
        if (q.opt1[B_MASKABLE_INT_EDGE_BIT] && irq_fall)
            d.irq_pend = 1'b1;                   // [R07]
        if (nonmaskable_int_pin_ack_i)
            d.nonmaskable_int_pin_pend = 1'b0;
        if (q.system_options_two[B_NONMASKABLE_INT_EDGE_BIT] && nonmaskable_int_pin_fall)
            d.nonmaskable_int_pin_pend = 1'b1;                  // [R22]
        // start-up delay after stop exit
        case (q.dl)
            DL_RUN: begin
                if (stop_exit_i) begin
                    d.dl     = DL_HOLD;
                    d.dl_cnt = q.opt1[B_DLY] ? DLY_POR : DLY_FAST; // [R08] [R09]
                end
            end
            DL_HOLD: begin
                d.dl_cnt = q.dl_cnt - 12'h001;
                if (q.dl_cnt == 12'h001)
                    d.dl = DL_RUN;
            end
            default: d.dl = DL_RUN;
        endcase
        // instruction start: low one cycle, then optional high drive
        d.lir_lo = instr_start_i & expanded;     // [R12]
        d.lir_hi = q.lir_lo & q.system_options_two[B_INSTR_START_DRIVE_BIT];
    end

    // state register; power-on delay starts with reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q           <= '0;
            q.mode      <= soc_mode_e'(mode_i);
            q.ee        <= EE_RST;
            q.opt1      <= OPT1_RST;             // [R08]
            q.system_options_two      <= SYSTEM_OPTIONS_TWO_RST;             // [R15]
            q.system_options_two[B_VIS] <= (mode_i == MODE_TEST); // [R16]
            q.irq_s     <= 3'b111;
            q.nonmaskable_int_pin_s    <= 3'b111;
            q.dl        <= DL_HOLD;
            q.dl_cnt    <= DLY_POR;              // [R09]
        end else begin
            q <= d;
        end
    end

    // bus outputs
    assign ack_o = q.ack;
    assign dat_o = {24'h000000, q.rdata};

    // configuration fields straight from flops
    assign cfg_o.eeprom_position_field   = q.ee;
    assign cfg_o.analog_power_bit        = q.opt1[B_ANALOG_POWER_BIT];  // [R05]
    assign cfg_o.pump_clock_select       = q.opt1[B_PUMP_CLOCK_SELECT];
    assign cfg_o.watchdog_rate_bits      = q.opt1[1:0];     // [R11]
    assign cfg_o.port_c_open_drain_bit   = q.system_options_two[B_PORT_C_OPEN_DRAIN_BIT];  // [R13]
    assign cfg_o.bit_order_bit           = q.system_options_two[B_BIT_ORDER_BIT];  // [R19]
    assign cfg_o.extra_rate_bit          = q.system_options_two[B_EXTRA_RATE_BIT];  // [R20]
    assign cfg_o.clock_output_source_bit = q.system_options_two[B_CLOCK_OUTPUT_SOURCE_BIT]; // [R21]

    // derived controls
    assign special_mode_o = special;
    assign eeprom_sel_o   = (cpu_addr_i[15:12] == q.ee)
                          & (cpu_addr_i[11:9] == 3'b111); // [R02]
    // rc clock is much slower than clk_i, so a rising edge is one tick
    assign pump_clk_en_o  = q.opt1[B_PUMP_CLOCK_SELECT] ?
                            (q.rc_s[1] & ~q.rc_s[2]) : 1'b1; // [R06]
    assign adc_ready_o    = q.opt1[B_ANALOG_POWER_BIT] & (q.adc_cnt == ADC_MAX);
    assign irq_req_o      = q.opt1[B_MASKABLE_INT_EDGE_BIT] ? q.irq_pend : ~q.irq_s[1];
    assign nonmaskable_int_pin_req_o     = q.system_options_two[B_NONMASKABLE_INT_EDGE_BIT] ? q.nonmaskable_int_pin_pend : ~q.nonmaskable_int_pin_s[1];
    assign cpu_run_o      = (q.dl == DL_RUN);
    assign monitor_en_o   = q.opt1[B_CME] | q.opt1[B_FORCE_MONITOR_BIT]; // [R10]
    assign clk_fail_rst_o = monitor_en_o & clk_slow_i;      // [R10]
    // one clk of drive stands in for the quarter bus cycle
    assign lir_o          = q.lir_hi;
    assign lir_oe_n_o     = ~(q.lir_lo | q.lir_hi);         // [R12]
    assign stretch_o      = expanded & q.system_options_two[B_STRETCH_BIT] & ext_access_i
                          & (rom_placement_i ? (cpu_addr_i[15:14] == 2'b00)
                                             : (cpu_addr_i[15:14] == 2'b11)); // [R14] [R15]
    assign read_vis_o     = expanded & q.system_options_two[B_VIS] & ~secure_i; // [R17]
    assign busclk_low_o   = ~expanded & q.system_options_two[B_VIS];       // [R18]
    assign clock_output_pin_oe_n_o    = ~clk_out_en_i;                   // [R24]

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_fall;
        q.irq_s[2] && !q.irq_s[1] && q.opt1[B_MASKABLE_INT_EDGE_BIT];
    endsequence
    sequence s_fast_exit;
        cpu_run_o && stop_exit_i && !q.opt1[B_DLY];
    endsequence

    chk_ee_low_zero: assert property (ack_o && $past(reg_hit(adr_i, IDX_EEMAP) && !we_i)
        |-> dat_o[3:0] == 4'h0) else $error("eeprom map low nibble not zero"); // [R03]
    chk_ee_once: assert property (!special && q.ee_wr && wr && reg_hit(adr_i, IDX_EEMAP)
        |=> $stable(q.ee)) else $error("eeprom position rewritten"); // [R01]
    chk_opt1_lock: assert property (!special && !in_window && wr && reg_hit(adr_i, IDX_OPT1)
        |=> (q.opt1 & OPT1_PROT) == ($past(q.opt1) & OPT1_PROT))
        else $error("protected option bits changed late"); // [R04]
    chk_force_monitor_bit_sticky: assert property (q.opt1[B_FORCE_MONITOR_BIT] |=> q.opt1[B_FORCE_MONITOR_BIT])
        else $error("forced monitor cleared"); // [R10]
    chk_fast_exit: assert property (s_fast_exit |=> !cpu_run_o [*4] ##1 cpu_run_o)
        else $error("fast exit not four cycles"); // [R08]
    chk_stretch_mode: assert property (stretch_o |-> expanded && q.system_options_two[B_STRETCH_BIT])
        else $error("stretch outside expanded mode"); // [R15]
    chk_vis_secure: assert property (secure_i |-> !read_vis_o)
        else $error("visibility while secure"); // [R17]
    chk_irq_edge: assert property (s_fall |=> irq_req_o)
        else $error("falling edge lost"); // [R07]
    chk_ee_decode: assert property (eeprom_sel_o |-> cpu_addr_i[15:9] == {q.ee, 3'b111})
        else $error("eeprom decode wrong"); // [R02]
    chk_lir_single: assert property (!expanded |-> lir_oe_n_o)
        else $error("instruction pin driven in single chip"); // [R12]

    // write-once option two fields hold after their first write in normal modes
    chk_vis_once: assert property (!special && q.vis_wr && wr && reg_hit(adr_i, IDX_SYSTEM_OPTIONS_TWO)
        |=> $stable(q.system_options_two[B_VIS])) else $error("visibility bit rewritten"); // [R16]
    chk_x4_once: assert property (!special && q.x4_wr && wr && reg_hit(adr_i, IDX_SYSTEM_OPTIONS_TWO)
        |=> $stable(q.system_options_two[B_CLOCK_OUTPUT_SOURCE_BIT])) else $error("clock source rewritten"); // [R21]
    chk_xe_once: assert property (!special && q.xe_wr && wr && reg_hit(adr_i, IDX_SYSTEM_OPTIONS_TWO)
        |=> $stable(q.system_options_two[B_NONMASKABLE_INT_EDGE_BIT])) else $error("nmi edge bit rewritten"); // [R22]

    // a latched edge request stays until software acknowledges it
    chk_irq_hold: assert property (q.irq_pend && !irq_ack_i |=> q.irq_pend)
        else $error("irq edge latch lost"); // [R07]

    // converter never reports ready while powered down
    chk_adc_off: assert property (!cfg_o.analog_power_bit |-> !adc_ready_o)
        else $error("converter ready while off"); // [R05]

    // bus clock pin is only held low outside expanded modes
    chk_busclk_exp: assert property (expanded |-> !busclk_low_o)
        else $error("bus clock held in expanded mode"); // [R18]

    // stretching only applies to accesses that leave the chip
    chk_stretch_ext: assert property (stretch_o |-> ext_access_i)
        else $error("stretch on internal access"); // [R14]

    // instruction start: low cycle, then high drive cycle when enabled
    sequence s_lir_start;
        instr_start_i && expanded && q.system_options_two[B_INSTR_START_DRIVE_BIT];
    endsequence
    sequence s_lir_pulse;
        (!lir_oe_n_o && !lir_o) ##1 (!lir_oe_n_o && lir_o);
    endsequence
    chk_lir_pulse: assert property (s_lir_start |=> s_lir_pulse)
        else $error("instruction start pulse wrong"); // [R12]

    // special indicator follows the latched mode straps
    chk_special_mode: assert property (special_mode_o == !q.mode[1])
        else $error("special indicator wrong"); // [R23]

endmodule : soc_regs
`default_nettype wire

// ### test/tb.sv
// tb: self-checking bench for the system option registers.
// assumes soc_regs from rtl/ with its Wishbone timing: ack one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import soc_pkg::*;
    localparam logic [7:0] A_EE = 8'hDC, A_O2 = 8'hE0, A_O1 = 8'hE4;
    logic        clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, secure = 1'b0;
    logic        clk_oe = 1'b0, rom_pl = 1'b0, ext_acc = 1'b0, irq_n = 1'b1, irq_ack = 1'b0;
    logic        rc = 1'b0, instr = 1'b0, clk_slow = 1'b0, stop = 1'b0, nonmaskable_int_pin_n = 1'b1;
    logic [1:0]  mode = 2'b10;
    logic [7:0]  adr = 8'h00, dat_w = 8'h00;
    logic [15:0] cpu_a = 16'h0000;
    logic [3:0]  pos;
    logic [31:0] dat_r;
    logic [7:0]  exp_q[$];
    int          err_total = 0, check_count = 0;
    wire         ack, eesel, pump, adc_rdy, irq_req, nonmaskable_int_pin_req, run, mon, fail, instruction_start_pin, lir_oe_n;
    wire         stretch_bit, rvis, bclk_low, clock_output_pin_oe_n, smode;
    soc_cfg_s    cfg;

    soc_regs #(.LONG_DELAY(1'b0), .ADC_SETTLE_CYC(20)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i({24'h000000, dat_w}), .dat_o(dat_r),
        .we_i(we), .sel_i(4'h1), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .mode_i(mode),
        .secure_i(secure), .clk_out_en_i(clk_oe), .rom_placement_i(rom_pl), .cpu_addr_i(cpu_a),
        .ext_access_i(ext_acc), .irq_n_i(irq_n), .nonmaskable_int_pin_n_i(nonmaskable_int_pin_n), .irq_ack_i(irq_ack),
        .nonmaskable_int_pin_ack_i(1'b0), .rc_tick_i(rc), .stop_exit_i(stop), .instr_start_i(instr),
        .clk_slow_i(clk_slow), .cfg_o(cfg), .special_mode_o(smode), .eeprom_sel_o(eesel),
        .pump_clk_en_o(pump), .adc_ready_o(adc_rdy), .irq_req_o(irq_req), .nonmaskable_int_pin_req_o(nonmaskable_int_pin_req),
        .cpu_run_o(run), .monitor_en_o(mon), .clk_fail_rst_o(fail), .lir_o(instruction_start_pin),
        .lir_oe_n_o(lir_oe_n), .stretch_o(stretch_bit), .read_vis_o(rvis), .busclk_low_o(bclk_low),
        .clock_output_pin_oe_n_o(clock_output_pin_oe_n));

    // 100 MHz bus clock
    always #5 clk_i = ~clk_i;
    // rc oscillator pin wanders at random so the pump path sees traffic
    always @(posedge clk_i) rc <= 1'($urandom);

    task automatic wrap_up();
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8

    task automatic lv(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask : lv

    // watcher: every read answer is matched against the oldest note
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                cmp8(dat_r[7:0], 8'hXX);
            end else begin
                cmp8(dat_r[7:0], exp_q.pop_front());
            end
        end
    end

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= a; we <= w; dat_w <= d; cyc <= 1'b1; stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        wb(a, 1'b0, 8'h00);
    endtask : rd

    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask : settle

    // reset for five cycles with the strap mode presented meanwhile
    task automatic rst(input logic [1:0] m);
        @(posedge clk_i);
        rst_i <= 1'b1; mode <= m;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : rst

    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #50000;
        err_total++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h32cf));
        rst(2'b10);
        settle(); lv(run, 1'b0);
        rd(A_EE, EE_RST); rd(A_O1, OPT1_RST); rd(A_O2, 8'h00); rd(8'hF0, 8'h00);
        // protected fields inside the window: first write lands, second is refused
        wb(A_O1, 1'b1, 8'h2F); rd(A_O1, 8'h2F);
        wb(A_O1, 1'b1, 8'h13); rd(A_O1, 8'h27);
        settle(); lv(mon, 1'b1);
        clk_slow <= 1'b1; settle(); settle(); lv(fail, 1'b1);
        clk_slow <= 1'b0;
        irq_n <= 1'b0; repeat (4) settle(); irq_n <= 1'b1; repeat (4) settle(); lv(irq_req, 1'b1);
        irq_ack <= 1'b1; settle(); irq_ack <= 1'b0; settle(); lv(irq_req, 1'b0);
        pos = 4'($urandom_range(15, 0));
        wb(A_EE, 1'b1, {pos, 4'hF}); rd(A_EE, {pos, 4'h0});
        wb(A_EE, 1'b1, ~{pos, 4'h0}); rd(A_EE, {pos, 4'h0});
        cpu_a <= {pos, 12'hE00}; settle(); settle(); lv(eesel, 1'b1);
        cpu_a <= {pos, 12'hDFF}; settle(); settle(); lv(eesel, 1'b0);
        wb(A_O2, 1'b1, 8'hFF); rd(A_O2, 8'hFF); wb(A_O2, 1'b1, 8'h00); rd(A_O2, 8'h13);
        // nonmaskable pin now edge sensitive: one falling edge must latch
        settle(); lv(nonmaskable_int_pin_req, 1'b0);
        nonmaskable_int_pin_n <= 1'b0; repeat (4) settle(); nonmaskable_int_pin_n <= 1'b1; repeat (4) settle(); lv(nonmaskable_int_pin_req, 1'b1);
        ext_acc <= 1'b1; rom_pl <= 1'b1; cpu_a <= 16'h1000;
        settle(); settle(); lv(bclk_low, 1'b1); lv(stretch_bit, 1'b0); lv(clock_output_pin_oe_n, 1'b1);
        lv(cfg.clock_output_source_bit, 1'b1); lv(cfg.bit_order_bit, 1'b0);
        // window runs out before the first write to options one
        rst(2'b10);
        repeat (70) settle();
        wb(A_O1, 1'b1, 8'h00); rd(A_O1, 8'h10);
        settle(); lv(run, 1'b0);
        repeat (60) settle(); lv(run, 1'b1);
        // special test mode: no write protection
        rst(2'b01);
        settle(); lv(smode, 1'b1);
        rd(A_O2, 8'h10);
        repeat (70) settle();
        wb(A_O1, 1'b1, 8'h80); rd(A_O1, 8'h80);
        settle(); lv(adc_rdy, 1'b0); repeat (22) settle(); lv(adc_rdy, 1'b1);
        wb(A_O2, 1'b1, 8'h03); wb(A_O2, 1'b1, 8'h0C); rd(A_O2, 8'h0C);
        settle(); lv(cfg.bit_order_bit, 1'b1); lv(cfg.extra_rate_bit, 1'b1);
        // expanded mode: visibility, stretch range, instruction start pin
        rst(2'b11);
        wb(A_O1, 1'b1, 8'h00);
        wb(A_O2, 1'b1, 8'hB0); rd(A_O2, 8'hB0);
        settle(); lv(rvis, 1'b1);
        secure <= 1'b1; settle(); settle(); lv(rvis, 1'b0);
        cpu_a <= 16'h2000; settle(); settle(); lv(stretch_bit, 1'b1);
        cpu_a <= 16'h8000; settle(); settle(); lv(stretch_bit, 1'b0);
        rom_pl <= 1'b0; cpu_a <= 16'hC000; settle(); settle(); lv(stretch_bit, 1'b1);
        clk_oe <= 1'b1; settle(); settle(); lv(clock_output_pin_oe_n, 1'b0);
        @(posedge clk_i); instr <= 1'b1;
        @(posedge clk_i); instr <= 1'b0;
        #1; lv(lir_oe_n, 1'b0); lv(instruction_start_pin, 1'b0);
        settle(); lv(lir_oe_n, 1'b0); lv(instruction_start_pin, 1'b1);
        // delay bit cleared above: stop exit resumes after four cycles
        repeat (110) settle(); lv(run, 1'b1);
        @(posedge clk_i); stop <= 1'b1;
        @(posedge clk_i); stop <= 1'b0;
        #1; lv(run, 1'b0);
        repeat (3) settle(); lv(run, 1'b0);
        settle(); lv(run, 1'b1);
        repeat (3) settle();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
